// ===== bench/lmo_chk.sv
// Port-level assertions for the line motion output block
`timescale 1ns/1ps
`default_nettype none
module lmo_chk
(
   // Clock, reset and bus
   input wire logic                 REF_CLK_I,
   input wire logic                 RST_I,
   input wire logic                 CYC_I,
   input wire logic                 STB_I,
   input wire logic                 ACK_O,
   // Machine outputs
   input wire lmo_pkg::lmo_motion_t MOTION_O,
   input wire lmo_pkg::lmo_press_t  PRESS_O,
   input wire logic                 ERROR_O
);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);
   // Fresh request answered after exactly one wait
   ack_late_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
      else $error("ack late");
   ack_one_a: assert property (ACK_O |=> !ACK_O)
      else $error("ack too long");
   // Only table codes of either scheme may show, plus run held while coasting
   motion_code_a: assert property (MOTION_O inside
      {4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h9, 4'hc, 4'hd})
      else $error("motion code");
   // Boost covers the whole punch, leads it and trails it
   punch_boost_a: assert property (PRESS_O.punch |-> PRESS_O.boost)
      else $error("punch without boost");
   boost_lead_a: assert property ($rose(PRESS_O.punch) |-> $past(PRESS_O.boost))
      else $error("boost not ahead");
   boost_tail_a: assert property ($fell(PRESS_O.boost) |-> !$past(PRESS_O.punch))
      else $error("boost dropped early");
   // Out of tolerance: no run, no press
   err_stop_a: assert property (ERROR_O |-> !MOTION_O.run)
      else $error("running with error");
   err_quiet_a: assert property ($rose(ERROR_O) |->
      (!PRESS_O.shear && !PRESS_O.punch)[*3])
      else $error("press fired on error");
endmodule
bind lmo_top lmo_chk u_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .CYC_I(CYC_I),
   .STB_I(STB_I), .ACK_O(ACK_O), .MOTION_O(MOTION_O), .PRESS_O(PRESS_O), .ERROR_O(ERROR_O));
`default_nettype wire

// ===== bench/lmo_enc.sv
// Measuring-wheel encoder model giving one quadrature edge per clock
`timescale 1ns/1ps
`default_nettype none
module lmo_enc
(
   // Clock and step request
   input  wire logic clk_i,
   input  wire logic go_i,
   input  wire logic dir_i,
   // Quadrature channels
   output logic      a_o,
   output logic      b_o
);
   logic [1:0] ph_q = 2'h0;
   // Gray order, so only one channel moves per step
   always_ff @(posedge clk_i)
      if (go_i)
         ph_q <= dir_i ? ph_q + 2'h1 : ph_q - 2'h1;
   assign a_o = ph_q[0] ^ ph_q[1];
   assign b_o = ph_q[1];
endmodule
`default_nettype wire

// ===== bench/lmo_top_bench.sv
// Self-checking bench for the line motion output block
`timescale 1ns/1ps
`default_nettype none
module lmo_top_bench;
   logic                 clk = 1'b0;
   logic                 rst = 1'b1;
   logic                 cyc = 1'b0;
   logic                 we = 1'b0;
   logic [31:0]          adr = 32'h0;
   logic [31:0]          wd = 32'h0;
   logic [31:0]          rd;
   logic [31:0]          q;
   logic                 ack;
   logic                 jf = 1'b0;
   logic                 jr = 1'b0;
   logic                 hlt = 1'b0;
   logic                 go = 1'b0;
   logic                 dir = 1'b0;
   logic                 ea;
   logic                 eb;
   logic                 err;
   logic [2:0]           m;
   lmo_pkg::lmo_motion_t mot;
   lmo_pkg::lmo_press_t  prs;
   int                   mismatches = 0;
   int                   compares = 0;
   // 200 MHz clock
   always #2.5 clk = ~clk;
   // Short millisecond keeps settle and press timers small
   lmo_top #(.MS_CYCLES(20)) uut (.REF_CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(cyc),
      .WE_I(we), .ADR_I(adr), .SEL_I(4'hf), .DAT_I(wd), .DAT_O(rd), .ACK_O(ack),
      .ENC_A_I(ea), .ENC_B_I(eb), .JOG_FWD_I(jf), .JOG_REV_I(jr), .HALT_I(hlt),
      .MOTION_O(mot), .PRESS_O(prs), .ERROR_O(err));
   lmo_enc enc (.clk_i(clk), .go_i(go), .dir_i(dir), .a_o(ea), .b_o(eb));
   task ck(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   // Classic cycle, held until ack is sampled
   task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= {24'h0, a};
      wd <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = rd;
      cyc <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task rc(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      ck(n, q, e);
   endtask
   // Below, at and above both limits; refused writes keep the old value
   task lim(input string n, input logic [7:0] a, input logic [31:0] lo, hi, d);
      wr(a, lo - 32'h1);
      rc(n, a, d);
      wr(a, lo);
      rc(n, a, lo);
      wr(a, hi);
      rc(n, a, hi);
      wr(a, hi + 32'h1);
      rc(n, a, hi);
   endtask
   task mo(input logic [3:0] e);
      repeat (3) @(posedge clk);
      ck("motion", {28'h0, mot}, {28'h0, e});
   endtask
   task hp(input logic [3:0] e);
      @(posedge clk);
      hlt <= 1'b1;
      @(posedge clk);
      hlt <= 1'b0;
      mo(e);
   endtask
   task st(input int n, input logic d);
      @(posedge clk);
      go <= 1'b1;
      dir <= d;
      repeat (n) @(posedge clk);
      go <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // Run, one edge onto target, gather press outputs, then halt
   task pc(input logic [2:0] e, input string n);
      wr(lmo_pkg::A_CMD, 32'h1);
      st(1, 1'b1);
      m = 3'h0;
      repeat (500)
      begin
         @(posedge clk);
         m = m | prs;
      end
      ck(n, {29'h0, m}, {29'h0, e});
      hp(4'h4);
   endtask
   task results;
      if (mismatches == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Hang guard, far beyond the expected run
   initial
   begin
      #200000;
      mismatches++;
      results;
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rc("unmapped", 8'h40, 32'h0);
      lim("tol", lmo_pkg::A_TOL, lmo_pkg::TOL_MIN, lmo_pkg::TOL_MAX, lmo_pkg::TOL_RST);
      lim("res", lmo_pkg::A_RES, lmo_pkg::RES_MIN, lmo_pkg::RES_MAX, lmo_pkg::RES_RST);
      lim("filt", lmo_pkg::A_FILT, 32'(lmo_pkg::FLT_MIN), 32'(lmo_pkg::FLT_MAX),
         32'(lmo_pkg::FLT_RST));
      lim("spd", lmo_pkg::A_SPD, 32'h0, lmo_pkg::SP_MAX, 32'h0);
      lim("dwell", lmo_pkg::A_BDWL, 32'h0, 32'(lmo_pkg::DWELL_MAX), 32'h0);
      for (int u = 0; u < 3; u++)
      begin
         wr(lmo_pkg::A_CTRL, 32'h40 | 32'(u << 3));
         rc("units", lmo_pkg::A_CTRL, 32'h40 | 32'(u << 3));
      end
      // Jogs first, while the sequencer is surely idle
      for (int s = 0; s < 2; s++)
      begin
         wr(lmo_pkg::A_CTRL, 32'h40 | 32'(s));
         mo(s ? 4'h0 : 4'h4);
         jf <= 1'b1;
         mo(s ? 4'h4 : 4'hc);
         jf <= 1'b0;
         jr <= 1'b1;
         mo(4'h6);
         jr <= 1'b0;
      end
      // Minimum slow distance beyond the part forces slow only in auto
      wr(lmo_pkg::A_PART, 32'h2710);
      wr(lmo_pkg::A_MINSL, 32'h4e20);
      for (int s = 0; s < 2; s++)
      begin
         wr(lmo_pkg::A_CTRL, 32'h40 | 32'(s));
         wr(lmo_pkg::A_CMD, 32'h1);
         mo(4'h9);
         hp(s ? 4'h0 : 4'h4);
         wr(lmo_pkg::A_CTRL, 32'h60 | 32'(s));
         wr(lmo_pkg::A_CMD, 32'h1);
         mo(s ? 4'h5 : 4'hd);
         hp(s ? 4'h0 : 4'h4);
      end
      wr(lmo_pkg::A_CTRL, 32'h40);
      wr(lmo_pkg::A_CMD, 32'h10);
      st(10, 1'b1);
      rc("pos", lmo_pkg::A_POSL, 32'h0262_5a00);
      st(4, 1'b0);
      rc("pos", lmo_pkg::A_POSL, 32'h016e_3600);
      wr(lmo_pkg::A_CTRL, 32'h42);
      st(2, 1'b1);
      rc("pos", lmo_pkg::A_POSL, 32'h00f4_2400);
      wr(lmo_pkg::A_CTRL, 32'h40);
      // One edge of 0.04 inch equals a 0.04 inch part
      wr(lmo_pkg::A_LEAD, 32'h1);
      wr(lmo_pkg::A_PRESS, 32'h2);
      wr(lmo_pkg::A_BDWL, 32'h1);
      wr(lmo_pkg::A_SPD, 32'h0);
      wr(lmo_pkg::A_TOL, lmo_pkg::TOL_RST);
      wr(lmo_pkg::A_PART, 32'h190);
      wr(lmo_pkg::A_CMD, 32'h10);
      pc(3'h7, "normal");
      wr(lmo_pkg::A_SPD, 32'h190);
      wr(lmo_pkg::A_FILL, 32'h0);
      wr(lmo_pkg::A_CMD, 32'h4);
      bus(lmo_pkg::A_CMD, 1'b0, 32'h0);
      ck("filler", {31'h0, q[1]}, 32'h1);
      pc(3'h4, "filler");
      pc(3'h7, "after filler");
      wr(lmo_pkg::A_PART, 32'hc8);
      wr(lmo_pkg::A_TOL, 32'h5);
      wr(lmo_pkg::A_CMD, 32'h10);
      pc(3'h0, "tolerance");
      ck("error", {31'h0, err}, 32'h1);
      wr(lmo_pkg::A_CMD, 32'h8);
      repeat (2) @(posedge clk);
      ck("error", {31'h0, err}, 32'h0);
      // Forward-wired line: run stays on while coasting, drops once still
      wr(lmo_pkg::A_CTRL, 32'h44);
      wr(lmo_pkg::A_PART, 32'h2710);
      wr(lmo_pkg::A_CMD, 32'h11);
      st(1, 1'b1);
      hp(4'h5);
      repeat (250) @(posedge clk);
      mo(4'h4);
      results;
   end
endmodule
`default_nettype wire

// ===== logic/lmo_pkg.sv
// Constants, register map and carrier types for the line motion output block
`default_nettype none
package lmo_pkg;
   // Clock and timing
   localparam int unsigned CLK_NS    = 5;
   localparam int unsigned MS_NS     = 1_000_000;
   localparam int unsigned SETTLE_MS = 10;
   // Register byte offsets
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_CMD   = 8'h04;
   localparam logic [7:0] A_PART  = 8'h08;
   localparam logic [7:0] A_FILL  = 8'h0c;
   localparam logic [7:0] A_SPD   = 8'h10;
   localparam logic [7:0] A_TOL   = 8'h14;
   localparam logic [7:0] A_RES   = 8'h18;
   localparam logic [7:0] A_FILT  = 8'h1c;
   localparam logic [7:0] A_MINSL = 8'h20;
   localparam logic [7:0] A_DECEL = 8'h24;
   localparam logic [7:0] A_LEAD  = 8'h28;
   localparam logic [7:0] A_PRESS = 8'h2c;
   localparam logic [7:0] A_BDWL  = 8'h30;
   localparam logic [7:0] A_POSL  = 8'h34;
   localparam logic [7:0] A_POSH  = 8'h38;
   localparam logic [7:0] A_SPEED = 8'h3c;
   // Control register fields
   localparam int unsigned C_SCHEME = 0;
   localparam int unsigned C_INV    = 1;
   localparam int unsigned C_LMV    = 2;
   localparam int unsigned C_UNITS  = 3;
   localparam int unsigned C_AUTO   = 5;
   localparam int unsigned C_TOLEN  = 6;
   localparam logic [6:0]  CTRL_RST = 7'h40;
   // Command register fields
   localparam int unsigned K_RUN  = 0;
   localparam int unsigned K_HALT = 1;
   localparam int unsigned K_COIL = 2;
   localparam int unsigned K_CLR  = 3;
   localparam int unsigned K_ZERO = 4;
   // Setting limits and reset values (lengths in 0.0001 inch, encoder resolution in 0.00000001 inch)
   localparam logic [31:0] SP_MAX    = 32'h0098_9680;
   localparam logic [31:0] TOL_MIN   = 32'h0000_0005;
   localparam logic [31:0] TOL_MAX   = 32'h0001_86a0;
   localparam logic [31:0] TOL_RST   = 32'h0000_03e8;
   localparam logic [31:0] RES_MIN   = 32'h0000_0fa0;
   localparam logic [31:0] RES_MAX   = 32'h003d_0900;
   localparam logic [31:0] RES_RST   = 32'h0004_93e0;
   localparam logic [10:0] FLT_MIN   = 11'h00a;
   localparam logic [10:0] FLT_MAX   = 11'h7d0;
   localparam logic [10:0] FLT_RST   = 11'h140;
   localparam logic [15:0] DWELL_MAX = 16'h270f;
   localparam logic [15:0] DECEL_RST = 16'h0064;
   // Scaling: 0.0001 inch to 0.00000001 inch, filter gain, speed display
   localparam logic [47:0] LEN_SCALE = 48'h0000_0000_2710;
   localparam logic [5:0]  FLT_GAIN  = 6'h29;
   localparam int unsigned FLT_SH    = 16;
   localparam logic [18:0] SPK_IMP   = 19'h51eb8;
   localparam logic [18:0] SPK_SI    = 19'h04296;
   localparam int unsigned SPK_SH    = 26;
   // Measurement unit selection
   typedef enum logic [1:0] {
      LMO_IMPERIAL_UNITS = 2'h0,
      LMO_SI_UNITS_MM    = 2'h1,
      LMO_SI_UNITS_CM    = 2'h2
   } lmo_units_t;
   // Machine motion state
   typedef enum logic [4:0] {
      M_HALT = 5'h01,
      M_FAST = 5'h02,
      M_SLOW = 5'h04,
      M_JOGF = 5'h08,
      M_JOGR = 5'h10
   } lmo_mot_t;
   // Part cycle sequencer state
   typedef enum logic [5:0] {
      S_IDLE   = 6'h01,
      S_FEED   = 6'h02,
      S_SETTLE = 6'h04,
      S_LEAD   = 6'h08,
      S_PRESS  = 6'h10,
      S_DWELL  = 6'h20
   } lmo_seq_t;
   // Speed and direction outputs 1, 2, 3 and 6
   typedef struct packed {
      logic fwd;
      logic slow;
      logic rev;
      logic run;
   } lmo_motion_t;
   // Press outputs
   typedef struct packed {
      logic shear;
      logic punch;
      logic boost;
   } lmo_press_t;
endpackage
`default_nettype wire

// ===== logic/lmo_top.sv
// Line motion, press output and encoder logic with a Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module lmo_top #(
   parameter int unsigned MS_CYCLES = lmo_pkg::MS_NS / lmo_pkg::CLK_NS
)
(
   // Clock and reset
   input  wire logic                 REF_CLK_I,
   input  wire logic                 RST_I,
   // Wishbone slave
   input  wire logic                 CYC_I,
   input  wire logic                 STB_I,
   input  wire logic                 WE_I,
   input  wire logic [31:0]          ADR_I,
   input  wire logic [3:0]           SEL_I,
   input  wire logic [31:0]          DAT_I,
   output logic      [31:0]          DAT_O,
   output logic                      ACK_O,
   // Machine inputs
   input  wire logic                 ENC_A_I,
   input  wire logic                 ENC_B_I,
   input  wire logic                 JOG_FWD_I,
   input  wire logic                 JOG_REV_I,
   input  wire logic                 HALT_I,
   // Machine outputs
   output lmo_pkg::lmo_motion_t      MOTION_O,
   output lmo_pkg::lmo_press_t       PRESS_O,
   output logic                      ERROR_O
);

   // Settings
   logic [6:0]          ctrl_q;
   logic [31:0]         part_q;
   logic [31:0]         fill_q;
   logic [31:0]         spd_dist_q;
   logic [31:0]         tol_q;
   logic [31:0]         res_q;
   logic [10:0]         filt_q;
   logic [31:0]         minsl_q;
   logic [15:0]         k_q;
   logic [15:0]         lead_q;
   logic [15:0]         press_q;
   logic [15:0]         bdwl_q;
   // Machine state
   lmo_pkg::lmo_mot_t   mot_q;
   lmo_pkg::lmo_mot_t   mot_d;
   lmo_pkg::lmo_seq_t   seq_q;
   lmo_pkg::lmo_seq_t   seq_d;
   logic                halt_q;
   logic                err_q;
   logic                filler_q;
   logic [31:0]         facc_q;
   logic [15:0]         tmr_q;
   logic [31:0]         pre_q;
   logic [4:0]          still_q;
   logic [1:0]          ab_q;
   logic signed [47:0]  pos_q;
   logic signed [47:0]  pos_tick_q;
   logic signed [31:0]  spd_q;
   // Bus and output state
   logic                ack_q;
   logic [31:0]         dat_q;
   lmo_pkg::lmo_motion_t mot_out_q;
   lmo_pkg::lmo_press_t  prs_out_q;
   logic [31:0]         speed_disp;

   // Bus decode: one-wait-state answer, unmapped reads return zero
   wire        req      = CYC_I & STB_I & ~ack_q;
   wire        wr       = req & WE_I;
   wire [7:0]  adr      = ADR_I[7:0];
   wire        in_range = (ADR_I[31:8] == 24'h0) & (ADR_I[1:0] == 2'h0);
   wire        w_ctrl   = wr & in_range & (adr == lmo_pkg::A_CTRL);
   wire        w_cmd    = wr & in_range & (adr == lmo_pkg::A_CMD) & SEL_I[0];
   wire        w_part   = wr & in_range & (adr == lmo_pkg::A_PART);
   wire        w_fill   = wr & in_range & (adr == lmo_pkg::A_FILL);
   wire        w_spd    = wr & in_range & (adr == lmo_pkg::A_SPD);
   wire        w_tol    = wr & in_range & (adr == lmo_pkg::A_TOL);
   wire        w_res    = wr & in_range & (adr == lmo_pkg::A_RES);
   wire        w_filt   = wr & in_range & (adr == lmo_pkg::A_FILT);
   wire        w_minsl  = wr & in_range & (adr == lmo_pkg::A_MINSL);
   wire        w_decel  = wr & in_range & (adr == lmo_pkg::A_DECEL);
   wire        w_lead   = wr & in_range & (adr == lmo_pkg::A_LEAD);
   wire        w_press  = wr & in_range & (adr == lmo_pkg::A_PRESS);
   wire        w_bdwl   = wr & in_range & (adr == lmo_pkg::A_BDWL);

   // Status word and current register value for reads and byte merging
   wire [31:0] status = {24'h0, mot_q, halt_q, filler_q, err_q};
   wire [31:0] cur =
      (adr == lmo_pkg::A_CTRL)  ? {25'h0, ctrl_q} :
      (adr == lmo_pkg::A_CMD)   ? status :
      (adr == lmo_pkg::A_PART)  ? part_q :
      (adr == lmo_pkg::A_FILL)  ? fill_q :
      (adr == lmo_pkg::A_SPD)   ? spd_dist_q :
      (adr == lmo_pkg::A_TOL)   ? tol_q :
      (adr == lmo_pkg::A_RES)   ? res_q :
      (adr == lmo_pkg::A_FILT)  ? {21'h0, filt_q} :
      (adr == lmo_pkg::A_MINSL) ? minsl_q :
      (adr == lmo_pkg::A_DECEL) ? {16'h0, k_q} :
      (adr == lmo_pkg::A_LEAD)  ? {16'h0, lead_q} :
      (adr == lmo_pkg::A_PRESS) ? {16'h0, press_q} :
      (adr == lmo_pkg::A_BDWL)  ? {16'h0, bdwl_q} :
      (adr == lmo_pkg::A_POSL)  ? pos_q[31:0] :
      (adr == lmo_pkg::A_POSH)  ? {{16{pos_q[47]}}, pos_q[47:32]} :
      (adr == lmo_pkg::A_SPEED) ? speed_disp : 32'h0;
   wire [31:0] rdata = in_range ? cur : 32'h0;

   // Byte lanes: unselected lanes keep the stored value
   logic [31:0] wv;
   genvar gl;
   generate
      for (gl = 0; gl < 4; gl++)
      begin : g_lane
         assign wv[gl*8 +: 8] = SEL_I[gl] ? DAT_I[gl*8 +: 8] : cur[gl*8 +: 8];
      end
   endgenerate

   // Range checks: an out-of-range write leaves the old value in place
   wire ok_spd  = wv <= lmo_pkg::SP_MAX;
   wire ok_tol  = (wv >= lmo_pkg::TOL_MIN) & (wv <= lmo_pkg::TOL_MAX);
   wire ok_res  = (wv >= lmo_pkg::RES_MIN) & (wv <= lmo_pkg::RES_MAX);
   wire ok_filt = (wv[31:11] == 21'h0) & (wv[10:0] >= lmo_pkg::FLT_MIN)
                & (wv[10:0] <= lmo_pkg::FLT_MAX);
   wire ok_dwl  = (wv[31:16] == 16'h0) & (wv[15:0] <= lmo_pkg::DWELL_MAX);

   // Command pulses
   wire cmd_run  = w_cmd & DAT_I[lmo_pkg::K_RUN];
   wire cmd_halt = w_cmd & DAT_I[lmo_pkg::K_HALT];
   wire cmd_coil = w_cmd & DAT_I[lmo_pkg::K_COIL];
   wire cmd_clr  = w_cmd & DAT_I[lmo_pkg::K_CLR];
   wire cmd_zero = w_cmd & DAT_I[lmo_pkg::K_ZERO];

   // Control fields
   wire scheme = ctrl_q[lmo_pkg::C_SCHEME];
   wire inv    = ctrl_q[lmo_pkg::C_INV];
   wire lmv    = ctrl_q[lmo_pkg::C_LMV];
   wire autok  = ctrl_q[lmo_pkg::C_AUTO];
   wire tol_en = ctrl_q[lmo_pkg::C_TOLEN];
   wire [1:0] units = ctrl_q[lmo_pkg::C_UNITS +: 2];

   // Quadrature: exactly one channel changed is a valid count
   wire edge_a = ENC_A_I ^ ab_q[1];
   wire edge_b = ENC_B_I ^ ab_q[0];
   wire step   = edge_a ^ edge_b;
   wire up     = (ENC_A_I ^ ab_q[0]) ^ inv;
   wire signed [47:0] res48 = $signed(48'(res_q));
   wire signed [47:0] dpos  = ~step ? 48'sh0 : (up ? res48 : -res48);

   // Millisecond tick and motion detect
   wire tick   = pre_q == 32'(MS_CYCLES - 1);
   wire moving = still_q != 5'(lmo_pkg::SETTLE_MS);
   wire coast  = halt_q & moving;

   // Piece length: filler pieces fall back to the order length when zero
   wire [31:0] fill_len  = (fill_q == 32'h0) ? part_q : fill_q;
   wire [31:0] piece_len = filler_q ? fill_len : part_q;
   wire signed [47:0] tgt = $signed(48'(piece_len) * lmo_pkg::LEN_SCALE);
   wire signed [47:0] rem = tgt - pos_q;
   wire signed [47:0] dev = pos_q - tgt;
   wire signed [47:0] tol48 = $signed(48'(tol_q) * lmo_pkg::LEN_SCALE);
   wire in_tol = (dev <= tol48) & (dev >= -tol48);
   wire at_tgt = pos_q >= tgt;

   // Slow-down distance: speed times learned decel time, plus minimum in auto
   wire [31:0] spd_pos = spd_q[31] ? 32'h0 : spd_q;
   wire [47:0] sl_base = 48'(spd_pos) * 48'(k_q);
   wire [47:0] sl_min  = autok ? 48'(minsl_q) * lmo_pkg::LEN_SCALE : 48'h0;
   wire [47:0] sl_dist = sl_base + sl_min;
   wire slow_zone = rem <= $signed(sl_dist);

   // First-order speed filter, corner set in 0.1 Hz steps, 1 ms samples
   wire signed [31:0] raw    = 32'(pos_q - pos_tick_q);
   wire signed [32:0] fdiff  = 33'(raw) - 33'(spd_q);
   wire [16:0]        fcoef  = 17'(filt_q) * 17'(lmo_pkg::FLT_GAIN);
   wire signed [55:0] fprod  = 56'(fdiff) * $signed(56'(fcoef));
   wire signed [31:0] spd_d  = spd_q + 32'(fprod >>> lmo_pkg::FLT_SH);

   // Speed shown in 0.01 ft/min for inches, mm/s for either si_units choice
   wire [18:0]        spk = (units == lmo_pkg::LMO_IMPERIAL_UNITS) ?
                            lmo_pkg::SPK_IMP : lmo_pkg::SPK_SI;
   wire signed [55:0] sprod = 56'(spd_q) * $signed(56'(spk));
   assign speed_disp = 32'(sprod >>> lmo_pkg::SPK_SH);

   // Press timing: filler pieces are shear only, no boost and no punch
   wire normal    = ~filler_q;
   wire lead_done = tmr_q >= lead_q;
   wire prs_done  = tmr_q >= press_q;
   wire dwl_done  = ~normal | (tmr_q >= bdwl_q);
   wire done      = (seq_q == lmo_pkg::S_DWELL) & dwl_done;
   wire tol_fail  = (seq_q == lmo_pkg::S_SETTLE) & ~moving & tol_en & ~in_tol;
   wire halt_set  = HALT_I | cmd_halt | tol_fail;
   wire err_d     = tol_fail | (err_q & ~cmd_clr);
   wire halt_d    = halt_set | (halt_q & ~cmd_run);
   wire [31:0] facc_nx = facc_q + piece_len;

   // Sequencer next state
   always_comb
   begin
      seq_d = seq_q;
      unique case (seq_q)
         lmo_pkg::S_IDLE:
            if (cmd_run & ~err_q & ~halt_set)
               seq_d = lmo_pkg::S_FEED;
         lmo_pkg::S_FEED:
            if (at_tgt & halt_q)
               seq_d = normal ? lmo_pkg::S_LEAD : lmo_pkg::S_PRESS;
            else if (at_tgt)
               seq_d = lmo_pkg::S_SETTLE;
            else if (halt_q & ~moving)
               seq_d = lmo_pkg::S_IDLE;
         lmo_pkg::S_SETTLE:
            if (tol_fail)
               seq_d = lmo_pkg::S_IDLE;
            else if (~moving)
               seq_d = normal ? lmo_pkg::S_LEAD : lmo_pkg::S_PRESS;
         lmo_pkg::S_LEAD:
            if (lead_done)
               seq_d = lmo_pkg::S_PRESS;
         lmo_pkg::S_PRESS:
            if (prs_done)
               seq_d = lmo_pkg::S_DWELL;
         lmo_pkg::S_DWELL:
            if (dwl_done)
               seq_d = halt_q ? lmo_pkg::S_IDLE : lmo_pkg::S_FEED;
      endcase
   end

   // Motion state: jog only when idle, always in slow speed
   assign mot_d = ((seq_q == lmo_pkg::S_IDLE) & JOG_REV_I) ? lmo_pkg::M_JOGR :
                  ((seq_q == lmo_pkg::S_IDLE) & JOG_FWD_I) ? lmo_pkg::M_JOGF :
                  ((seq_q == lmo_pkg::S_FEED) & ~halt_q) ?
                  (slow_zone ? lmo_pkg::M_SLOW : lmo_pkg::M_FAST) :
                  lmo_pkg::M_HALT;

   // Output decode for both wiring schemes
   wire st_fast = mot_q == lmo_pkg::M_FAST;
   wire st_slow = mot_q == lmo_pkg::M_SLOW;
   wire st_jogf = mot_q == lmo_pkg::M_JOGF;
   wire st_jogr = mot_q == lmo_pkg::M_JOGR;
   lmo_pkg::lmo_motion_t dec;
   assign dec.fwd  = scheme ? st_fast : (st_fast | st_slow | st_jogf);
   assign dec.slow = scheme ? (st_slow | st_jogf | st_jogr) : ~st_fast;
   assign dec.rev  = st_jogr;
   // Forward-wired lines keep run on while the material coasts
   assign dec.run  = st_fast | st_slow | (coast & lmv);

   // Press outputs
   lmo_pkg::lmo_press_t prs;
   wire in_cyc = (seq_q == lmo_pkg::S_LEAD) | (seq_q == lmo_pkg::S_PRESS)
               | (seq_q == lmo_pkg::S_DWELL);
   assign prs.shear = seq_q == lmo_pkg::S_PRESS;
   assign prs.punch = (seq_q == lmo_pkg::S_PRESS) & normal;
   assign prs.boost = in_cyc & normal;

   // Wishbone answer
   always_ff @(posedge REF_CLK_I)
   begin
      if (RST_I)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end
      else
      begin
         ack_q <= req;
         dat_q <= req ? rdata : dat_q;
      end
   end

   // Settings written by software
   always_ff @(posedge REF_CLK_I)
   begin
      if (RST_I)
      begin
         ctrl_q     <= lmo_pkg::CTRL_RST;
         part_q     <= 32'h0;
         fill_q     <= 32'h0;
         spd_dist_q <= 32'h0;
         tol_q      <= lmo_pkg::TOL_RST;
         res_q      <= lmo_pkg::RES_RST;
         filt_q     <= lmo_pkg::FLT_RST;
         minsl_q    <= 32'h0;
         lead_q     <= 16'h0;
         press_q    <= 16'h0;
         bdwl_q     <= 16'h0;
      end
      else
      begin
         if (w_ctrl) ctrl_q <= wv[6:0];
         if (w_part) part_q <= wv;
         if (w_fill) fill_q <= wv;
         if (w_spd & ok_spd) spd_dist_q <= wv;
         if (w_tol & ok_tol) tol_q <= wv;
         if (w_res & ok_res) res_q <= wv;
         if (w_filt & ok_filt) filt_q <= wv[10:0];
         if (w_minsl) minsl_q <= wv;
         if (w_lead & ok_dwl) lead_q <= wv[15:0];
         if (w_press & ok_dwl) press_q <= wv[15:0];
         if (w_bdwl & ok_dwl) bdwl_q <= wv[15:0];
      end
   end

   // Slowdown_learning_setting: software sets it, auto mode nudges it after each settled stop that lands outside tolerance
   always_ff @(posedge REF_CLK_I)
   begin
      if (RST_I)
         k_q <= lmo_pkg::DECEL_RST;
      else if (w_decel)
         k_q <= wv[15:0];
      else if (autok & (seq_q == lmo_pkg::S_SETTLE) & ~moving)
      begin
         // Overshoot asks for an earlier shift to slow
         if ((dev > tol48) & (k_q != 16'hffff))
            k_q <= k_q + 16'h1;
         else if ((dev < -tol48) & (k_q != 16'h0))
            k_q <= k_q - 16'h1;
      end
   end

   // Position, measured from the last cut
   always_ff @(posedge REF_CLK_I)
   begin
      if (RST_I | cmd_zero | cmd_coil)
         pos_q <= 48'sh0;
      else if (done)
         pos_q <= pos_q - tgt + dpos;
      else
         pos_q <= pos_q + dpos;
   end

   // Encoder history, tick prescaler, standstill timer, speed
   always_ff @(posedge REF_CLK_I)
   begin
      if (RST_I)
      begin
         ab_q       <= 2'h0;
         pre_q      <= 32'h0;
         still_q    <= 5'(lmo_pkg::SETTLE_MS);
         pos_tick_q <= 48'sh0;
         spd_q      <= 32'sh0;
      end
      else
      begin
         ab_q       <= {ENC_A_I, ENC_B_I};
         pre_q      <= tick ? 32'h0 : pre_q + 32'h1;
         still_q    <= step ? 5'h0 : (tick & moving) ? still_q + 5'h1 : still_q;
         // Speed sampled on a cut would jump by the part length
         pos_tick_q <= tick ? pos_q : (done ? pos_tick_q - tgt : pos_tick_q);
         spd_q      <= tick ? spd_d : spd_q;
      end
   end

   // Sequencer, flags and filler bookkeeping
   always_ff @(posedge REF_CLK_I)
   begin
      if (RST_I)
      begin
         seq_q    <= lmo_pkg::S_IDLE;
         mot_q    <= lmo_pkg::M_HALT;
         tmr_q    <= 16'h0;
         halt_q   <= 1'b1;
         err_q    <= 1'b0;
         filler_q <= 1'b0;
         facc_q   <= 32'h0;
      end
      else
      begin
         seq_q  <= seq_d;
         mot_q  <= mot_d;
         tmr_q  <= (seq_d != seq_q) ? 16'h0 : (tick ? tmr_q + 16'h1 : tmr_q);
         halt_q <= halt_d;
         err_q  <= err_d;
         if (cmd_coil)
         begin
            filler_q <= spd_dist_q != 32'h0;
            facc_q   <= 32'h0;
         end
         else if (done & filler_q)
         begin
            // Stop once the next part starts past the punch station
            facc_q   <= facc_nx;
            filler_q <= facc_nx < spd_dist_q;
         end
      end
   end

   // Registered outputs keep decode glitches off the drive wiring
   always_ff @(posedge REF_CLK_I)
   begin
      if (RST_I)
      begin
         mot_out_q <= '0;
         prs_out_q <= '0;
      end
      else
      begin
         mot_out_q <= dec;
         prs_out_q <= prs;
      end
   end

   assign ACK_O    = ack_q;
   assign DAT_O    = dat_q;
   assign MOTION_O = mot_out_q;
   assign PRESS_O  = prs_out_q;
   assign ERROR_O  = err_q;

endmodule
`default_nettype wire
